// File: hw/serial_sampling_adc_port.sv
// Summary of operation
// - The port acts on its serial lines only while chip select is low.
// - With chip select high the port is off, unpowered and not driving.
// - The result leaves serially on the output, timed by the shift clock.
// - Single-input variant: no input word, always the fixed input pair.
// - Single-input variant sends the result MSB first, then LSB first.
// - Input bits are valid at and sampled on the shift clock rising edge.
// - After select falls, zeros are dropped and the first one is the start.
// - The start bit begins capture of the setup bits and the transfer.
// - After the input word, input bits are ignored until select cycles.
// - The two bits after start select the input pair and its polarity.
// - In single-ended mode the chosen channel is measured against ground.
// - Bit-order one sends MSB first only, then zeros while clocks go on.
// - Bit-order zero sends MSB first, then repeats it LSB first.
// - The input is sampled over 1.5 shift clock cycles before conversion.
`timescale 1ns/1ps

module serial_sampling_adc_port
	import adc_port_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic select_and_power_down_n,
	input wire logic shift_clk,
	input wire logic serial_in,
	input wire logic single_input_mode,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire logic [RESULT_W-1:0] analog_channel_zero,
	input wire logic [RESULT_W-1:0] analog_channel_one,
	output logic serial_out,
	output logic serial_out_oe,
	output logic power_enable,
	output logic single_ended_select,
	output logic odd_polarity,
	output logic bit_order_select,
	output logic [RESULT_W-1:0] conversion_result
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] cs_sync_q, sclk_sync_q, din_sync_q;
	logic sclk_prev_q;
	logic cs_high, sclk_rise, sclk_fall, din_bit;

	// Two flops per pin; only the second stage feeds logic
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cs_sync_q <= 2'h3;
			sclk_sync_q <= 2'h0;
			din_sync_q <= 2'h0;
			sclk_prev_q <= 1'b0;
		end else begin
			cs_sync_q <= {cs_sync_q[0], select_and_power_down_n};
			sclk_sync_q <= {sclk_sync_q[0], shift_clk};
			din_sync_q <= {din_sync_q[0], serial_in};
			sclk_prev_q <= sclk_sync_q[1];
		end
	end

	assign cs_high = cs_sync_q[1];
	assign din_bit = din_sync_q[1];
	assign sclk_rise = sclk_sync_q[1] && !sclk_prev_q;
	assign sclk_fall = !sclk_sync_q[1] && sclk_prev_q;

	// ----------------------------------------------------------------
	// Sample buffer between the sampler and the converter
	// ----------------------------------------------------------------
	logic buf_valid, take_sample;
	logic [2*RESULT_W-1:0] buf_data;

	sample_buffer #(
		.W(2*RESULT_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk(clk),
		.rstn(rstn),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data({analog_channel_zero, analog_channel_one}),
		.out_valid(buf_valid),
		.out_ready(take_sample),
		.out_data(buf_data)
	);

	// ----------------------------------------------------------------
	// Conversion of the held channel levels
	// ----------------------------------------------------------------
	// Unipolar result, so a negative difference reads as zero
	function automatic logic [RESULT_W-1:0] convert(
		input logic sgl,
		input logic pol,
		input logic [RESULT_W-1:0] c0,
		input logic [RESULT_W-1:0] c1
	);
		logic [RESULT_W-1:0] pos, neg;
		pos = pol ? c1 : c0;
		neg = pol ? c0 : c1;
		if (sgl) begin
			convert = pos;
		end else begin
			convert = (pos > neg) ? pos - neg : '0;
		end
	endfunction : convert

	// ----------------------------------------------------------------
	// Port sequencer
	// ----------------------------------------------------------------
	port_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CFG_BITS-1:0] cfg_q, cfg_d;
	logic sgl_q, sgl_d, pol_q, pol_d, order_q, order_d;
	logic dout_q, dout_d, oe_q, oe_d;
	logic [RESULT_W-1:0] res_q, res_d, hold0_q, hold0_d, hold1_q, hold1_d;
	logic [CNT_W-1:0] idx;
	logic [RESULT_W-1:0] c0, c1;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		cfg_d = cfg_q;
		sgl_d = sgl_q;
		pol_d = pol_q;
		order_d = order_q;
		dout_d = dout_q;
		oe_d = oe_q;
		res_d = res_q;
		hold0_d = hold0_q;
		hold1_d = hold1_q;
		take_sample = 1'b0;
		idx = '0;
		// Fresh sample if one waits, else reuse the last one held
		c0 = buf_valid ? buf_data[2*RESULT_W-1:RESULT_W] : hold0_q;
		c1 = buf_valid ? buf_data[RESULT_W-1:0] : hold1_q;
		if (cs_high) begin
			state_d = ST_OFF;
			oe_d = 1'b0;
			dout_d = 1'b0;
		end else begin
			case (state_q)
				ST_OFF: begin
					state_d = ST_HUNT;
					cnt_d = '0;
					cfg_d = '0;
				end
				ST_HUNT: begin
					if (sclk_rise && single_input_mode) begin
						// Fixed pair, both bit orders, window opens now
						sgl_d = 1'b0;
						pol_d = 1'b0;
						order_d = 1'b0;
						state_d = ST_RUN;
					end else if (sclk_rise && din_bit) begin
						state_d = ST_CFG;
					end
				end
				ST_CFG: begin
					if (sclk_rise) begin
						cfg_d = {cfg_q[CFG_BITS-2:0], din_bit};
						cnt_d = cnt_q + 5'h01;
						if (cnt_q == CNT_W'(CFG_BITS - 1)) begin
							sgl_d = cfg_q[CFG_SGL_POS-1];
							pol_d = cfg_q[CFG_POL_POS-1];
							order_d = din_bit;
							cnt_d = '0;
							// Window opens on the last input bit
							state_d = ST_RUN;
						end
					end
				end
				ST_RUN: begin
					// Input pin no longer looked at in this state
					if (sclk_fall) begin
						cnt_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 5'h01;
						dout_d = 1'b0;
						if (cnt_d == ENABLE_FALL) begin
							oe_d = 1'b1;
						end
						if (cnt_d == SAMPLE_END_FALL) begin
							take_sample = 1'b1;
							hold0_d = c0;
							hold1_d = c1;
							res_d = convert(sgl_q, pol_q, c0, c1);
						end
						if (cnt_d >= MSB_FIRST_FALL &&
						    cnt_d <= MSB_LAST_FALL) begin
							idx = MSB_LAST_FALL - cnt_d;
							dout_d = res_q[idx[2:0]];
						end else if (cnt_d > MSB_LAST_FALL &&
						             cnt_d <= LSB_LAST_FALL &&
						             !order_q) begin
							idx = cnt_d - MSB_LAST_FALL;
							dout_d = res_q[idx[2:0]];
						end
						// Otherwise zeros fill the line
					end
				end
				default: begin
					state_d = ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_OFF;
			cnt_q <= '0;
			cfg_q <= '0;
			sgl_q <= 1'b0;
			pol_q <= 1'b0;
			order_q <= 1'b0;
			dout_q <= 1'b0;
			oe_q <= 1'b0;
			res_q <= '0;
			hold0_q <= '0;
			hold1_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cfg_q <= cfg_d;
			sgl_q <= sgl_d;
			pol_q <= pol_d;
			order_q <= order_d;
			dout_q <= dout_d;
			oe_q <= oe_d;
			res_q <= res_d;
			hold0_q <= hold0_d;
			hold1_q <= hold1_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign serial_out = dout_q;
	assign serial_out_oe = oe_q;
	assign power_enable = !cs_high;
	assign single_ended_select = sgl_q;
	assign odd_polarity = pol_q;
	assign bit_order_select = order_q;
	assign conversion_result = res_q;

endmodule : serial_sampling_adc_port

// File: hw/adc_port_pkg.sv
package adc_port_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int RESULT_W = 8;
	localparam int CFG_BITS = 3;
	localparam int CNT_W = 5;
	localparam int BUF_DEPTH = 2;

	// ----------------------------------------------------------------
	// Input word layout, bits after the start bit, first received first
	// ----------------------------------------------------------------
	localparam int CFG_SGL_POS = 2;
	localparam int CFG_POL_POS = 1;
	localparam int CFG_ORDER_POS = 0;

	// ----------------------------------------------------------------
	// Timing, counted in shift clock falling edges of the run phase
	// ----------------------------------------------------------------
	// Sample window in half shift clock cycles (1.5 cycles)
	localparam int SAMPLE_WINDOW_TIME_HALVES = 3;
	// Falling edge that closes the window, window opens on a rising edge
	localparam logic [CNT_W-1:0] SAMPLE_END_FALL =
		CNT_W'((SAMPLE_WINDOW_TIME_HALVES + 1) / 2);
	localparam logic [CNT_W-1:0] ENABLE_FALL = 5'h01;
	localparam logic [CNT_W-1:0] MSB_FIRST_FALL = SAMPLE_END_FALL + 5'h01;
	localparam logic [CNT_W-1:0] MSB_LAST_FALL =
		MSB_FIRST_FALL + CNT_W'(RESULT_W - 1);
	localparam logic [CNT_W-1:0] LSB_LAST_FALL =
		MSB_LAST_FALL + CNT_W'(RESULT_W - 1);
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;

	// ----------------------------------------------------------------
	// Port sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_OFF,
		ST_HUNT,
		ST_CFG,
		ST_RUN
	} port_state_t;

endpackage : adc_port_pkg

// File: hw/sample_buffer.sv
`timescale 1ns/1ps

// Small valid/ready buffer; depth two lets the source get two words ahead, then holds it off
// while the consumer takes its one word per frame.
module sample_buffer #(
	parameter int W = 16,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] mem_d [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	// ----------------------------------------------------------------
	// Handshake and pointer update
	// ----------------------------------------------------------------
	// Ready honestly reflects fullness so the source is held off
	assign in_ready = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_data;
			wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

endmodule : sample_buffer

// File: testbench/adc_port_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Pin timing checks on the converter port
// ------------------------------------------------------------
module adc_port_checker
	import adc_port_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic select_and_power_down_n,
	input wire logic shift_clk,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic power_enable,
	input wire logic bit_order_select,
	input wire logic [RESULT_W-1:0] conversion_result
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Windows allow for the two-flop pin synchronisers
	off_hiz_a:
	assert property (select_and_power_down_n [*5] |-> !serial_out_oe)
		else $error("output driven while deselected");
	power_off_a:
	assert property (select_and_power_down_n [*3] |-> !power_enable)
		else $error("powered while deselected");
	power_on_a:
	assert property ($rose(power_enable) |->
		!$past(select_and_power_down_n, 2)) else $error("power without select");
	oe_on_a:
	assert property ($rose(serial_out_oe) |-> power_enable && !shift_clk
		&& !serial_out) else $error("output enabled out of turn");
	dout_edge_a:
	assert property ($changed(serial_out) |-> !shift_clk && !$past(shift_clk))
		else $error("data changed away from a falling edge");
	oe_still_a:
	assert property (shift_clk [*2] |-> $stable(serial_out_oe))
		else $error("enable moved while shift clock high");
	cfg_rise_a:
	assert property ($changed(bit_order_select) |-> $past(shift_clk))
		else $error("input bit taken off a rising edge");
	result_gate_a:
	assert property ($changed(conversion_result) |-> power_enable && !shift_clk)
		else $error("result changed outside the sample point");
endmodule : adc_port_checker

bind serial_sampling_adc_port adc_port_checker u_chk (
	.clk(clk), .rstn(rstn), .shift_clk(shift_clk),
	.select_and_power_down_n(select_and_power_down_n),
	.serial_out(serial_out), .serial_out_oe(serial_out_oe),
	.power_enable(power_enable), .bit_order_select(bit_order_select),
	.conversion_result(conversion_result)
);

// File: testbench/host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side: select, shift clock and input word
// ------------------------------------------------------------
module host_model (
	input wire logic clk,
	output logic select_and_power_down_n,
	output logic shift_clk,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	logic [19:0] dout_q = 20'h00000;
	logic [19:0] oe_q = 20'h00000;
	// Shift clock stands low outside frames
	initial begin
		select_and_power_down_n = 1'b1;
		shift_clk = 1'b0;
		serial_in = 1'b0;
	end
	// One 80 ns shift cycle; output sampled late in the high phase
	task automatic cyc(input logic din);
		serial_in <= din;
		repeat (4) @(posedge clk);
		shift_clk <= 1'b1;
		repeat (4) @(posedge clk);
		// A released line reads inverted so an undriven bit cannot pass
		dout_q = {dout_q[18:0], serial_out_oe ? serial_out : ~serial_out};
		oe_q = {oe_q[18:0], serial_out_oe};
		shift_clk <= 1'b0;
	endtask : cyc
	// Whole frame; unused input bits toggle so a stray capture shows
	task automatic frame(input logic one, sgl, pol, ord);
		select_and_power_down_n <= 1'b0;
		repeat (6) @(posedge clk);
		if (!one) begin
			cyc(1'b0);
			cyc(1'b0);
			cyc(1'b1);
			cyc(sgl);
			cyc(pol);
			cyc(ord);
		end
		for (int i = 0; i < (one ? 21 : 20); i++) cyc(~serial_in);
		repeat (2) @(posedge clk);
		select_and_power_down_n <= 1'b1;
		repeat (10) @(posedge clk);
	endtask : frame
endmodule : host_model

// File: testbench/testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Converter port bench
// ------------------------------------------------------------
module testbench;
	import adc_port_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic single_input_mode = 1'b0;
	logic sample_valid = 1'b0;
	logic [RESULT_W-1:0] lvl_zero = 8'h00;
	logic [RESULT_W-1:0] lvl_one = 8'h00;
	logic sel_n, sclk, sdin, sdout, sdout_oe, pwr, sgl, pol, ord, ready;
	logic [RESULT_W-1:0] result;
	int err_count = 0;
	int comparisons = 0;
	// One word and mode {single, sgl, pol, order} per frame
	logic [7:0] wa [6] = '{8'hb4, 8'h13, 8'hc8, 8'h21, 8'h9e, 8'h70};
	logic [7:0] wb [6] = '{8'h2d, 8'he6, 8'h45, 8'h7a, 8'h1c, 8'h90};
	logic [3:0] modes [6] = '{4'h5, 4'h6, 4'h1, 4'h2, 4'h8, 4'h3};
	always #5 clk = ~clk;
	serial_sampling_adc_port u_dut (
		.clk(clk), .rstn(rstn), .select_and_power_down_n(sel_n),
		.shift_clk(sclk), .serial_in(sdin),
		.single_input_mode(single_input_mode), .sample_valid(sample_valid),
		.sample_ready(ready), .analog_channel_zero(lvl_zero),
		.analog_channel_one(lvl_one), .serial_out(sdout),
		.serial_out_oe(sdout_oe), .power_enable(pwr),
		.single_ended_select(sgl), .odd_polarity(pol),
		.bit_order_select(ord), .conversion_result(result)
	);
	host_model u_host (
		.clk(clk), .select_and_power_down_n(sel_n), .shift_clk(sclk),
		.serial_in(sdin), .serial_out(sdout), .serial_out_oe(sdout_oe)
	);
	task automatic summarize();
		if (err_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	task automatic check(input string what, input logic [19:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Negative differences clamp to zero
	function automatic logic [7:0] expected(input logic one, s, p,
		input logic [7:0] a, b);
		if (!one && s) return p ? b : a;
		if (!one && p) return (b > a) ? b - a : 8'h00;
		return (a > b) ? a - b : 8'h00;
	endfunction : expected
	// Offer one word; a full buffer holds it off, bounded wait
	task automatic push(input logic [7:0] a, b);
		int n;
		for (n = 0; n < 50 && ready !== 1'b1; n++) @(posedge clk);
		if (n == 50) begin
			err_count++;
			summarize();
		end
		sample_valid <= 1'b1;
		lvl_zero <= a;
		lvl_one <= b;
		@(posedge clk);
		sample_valid <= 1'b0;
		@(posedge clk);
	endtask : push
	// Idle after reset, then fill the buffer with no frame to drain it
	task automatic t_reset_fill();
		check("idle", {sdout, sdout_oe, pwr, ready}, 20'h1);
		push(wa[0], wb[0]);
		push(wa[1], wb[1]);
		check("full", ready, 20'h0);
	endtask : t_reset_fill
	// Every mux code, both orders, and the single-input variant
	task automatic t_frames();
		logic [7:0] r;
		logic [19:0] e;
		for (int i = 0; i < 6; i++) begin
			if (i >= 2) push(wa[i], wb[i]);
			single_input_mode <= modes[i][3];
			r = expected(modes[i][3], modes[i][2], modes[i][1], wa[i], wb[i]);
			e = {2'h0, r, 7'h00, 3'h0};
			if (modes[i][3] || !modes[i][0]) e[9:3] = {r[1], r[2], r[3],
				r[4], r[5], r[6], r[7]};
			u_host.frame(modes[i][3], modes[i][2], modes[i][1], modes[i][0]);
			check("dout", u_host.dout_q, e);
			check("oe", u_host.oe_q, 20'hfffff);
			check("result", result, r);
			if (!modes[i][3]) check("cfg", {sgl, pol, ord}, modes[i][2:0]);
			check("off", {sdout_oe, pwr, ready}, 20'h1);
		end
	endtask : t_frames
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset_fill();
		t_frames();
		summarize();
	end
endmodule : testbench
